//--- rtl/isb_agent.sv
// carrier-side agent for a pipelined split-transaction i/o bus
// assumes pins are resolved outside; every pin is active low; inputs synchronous
// Overview of operation
// - priority request makes the high-priority agent next request-bus owner.
// - while block-new-request is asserted, the owner issues no new request.
// - lock stays asserted across an indivisible sequence of transactions.
// - each request spans two cycles; strobe only in the first.
// - request field carries type first cycle, size and length second.
// - request parity covers strobe and low four request bits; checked.
// - address bits 35 to 3 go with the request; transfers eight-byte aligned.
// - address parity upper covers 35..24, lower covers 23..3.
// - address or request parity mismatch asserts address-error.
// - clean copy held asserts clean-snoop in the snoop phase.
// - modified copy asserts dirty-snoop and the agent supplies the line.
// - clean and dirty together extend the snoop window, not a result.
// - addressed agent asserts defer when in-order completion is not assured.
// - three-bit response code with parity over those bits.
// - target-ready marks each data beat, from the response cycle on, and qualifies data.
// - 64-bit data with one parity bit per byte lane.
// - data-busy held by the owner across multi-cycle transfers.
// - unrecoverable data error asserts bus-error.
// - the bus is shared by four bridge agents, each requester and responder.
`timescale 1ns/1ps
module isb_agent
(
  input wire logic ref_clk,
  input wire logic rst_b,
  // user request side
  input wire logic reqValid,
  input wire isb_pkg::isb_request_type reqIn,
  output logic reqReady,
  input wire logic busRequestIn_n,
  output logic busRequestOut_n,
  // request pins
  input wire logic priority_agent_request_n,
  input wire logic block_new_request_n,
  output logic blockNewRequestOut_n,
  input wire logic lockIn_n,
  output logic lockOut_n,
  output logic lockOe,
  input wire logic request_strobe_n,
  output logic requestStrobeOut_n,
  output logic requestStrobeOe,
  input wire logic [isb_pkg::ReqW-1:0] requestIn_n,
  output logic [isb_pkg::ReqW-1:0] requestOut_n,
  input wire logic request_parity_n,
  output logic requestParityOut_n,
  input wire logic [isb_pkg::AddrHi:isb_pkg::AddrLo] addressIn_n,
  output logic [isb_pkg::AddrHi:isb_pkg::AddrLo] addressOut_n,
  input wire logic [1:0] address_parity_n,
  output logic [1:0] addressParityOut_n,
  input wire logic address_error_n,
  output logic addressErrorOut_n,
  // snoop, response and data pins
  input wire logic snoopCleanIn_n,
  input wire logic snoop_dirty_n,
  output logic snoopCleanOut_n,
  output logic snoopDirtyOut_n,
  input wire logic completion_deferred_n,
  output logic completionDeferredOut_n,
  input wire logic [isb_pkg::RespW-1:0] response_code_n,
  output logic [isb_pkg::RespW-1:0] responseCodeOut_n,
  input wire logic response_parity_n,
  output logic responseParityOut_n,
  input wire logic target_ready_n,
  output logic targetReadyOut_n,
  input wire logic [isb_pkg::DataW-1:0] dataIn_n,
  output logic [isb_pkg::DataW-1:0] dataOut_n,
  output logic dataOe,
  input wire logic [isb_pkg::Lanes-1:0] data_byte_parity_n,
  output logic [isb_pkg::Lanes-1:0] dataByteParityOut_n,
  input wire logic data_busy_n,
  output logic dataBusyOut_n,
  input wire logic bus_initialise_n,
  input wire logic bus_error_n,
  output logic busErrorOut_n,
  // user answer side
  input wire logic answerValid,
  input wire isb_pkg::isb_answer_type answerIn,
  input wire logic [isb_pkg::DataW-1:0] answerData,
  input wire logic dataUncorrectable,
  input wire logic userBlock,
  output isb_pkg::isb_seen_type seen,
  output logic [isb_pkg::DataW-1:0] readData,
  output logic readValid,
  output logic seenBusError,
  output logic seenInit
);
  // parity over wire levels; odd count of low bits gives low parity
  function automatic logic wireParity(input logic [63:0] v, input logic [63:0] m);
    wireParity = ~(^(~v & m));
  endfunction

  function automatic logic [63:0] laneMask(input int lo, input int hi);
    logic [63:0] m;
    m = '0;
    for (int i = lo; i <= hi; i++)
      m[i] = 1'b1;
    laneMask = m;
  endfunction

  isb_pkg::isb_req_state_type reqState;
  isb_pkg::isb_request_type held;
  logic lockHeld;
  logic sawStrobe;
  logic [isb_pkg::ReqW-1:0] firstReq;
  logic firstStrobe;
  logic [3:0] beatsLeft;
  logic [isb_pkg::AddrHi:isb_pkg::AddrLo] seenAddr;
  logic [isb_pkg::ReqW-1:0] seenType;

  wire busInit = ~bus_initialise_n;
  // the high-priority agent always wins the next ownership
  wire mayIssue = ~priority_agent_request_n ? 1'b0 : block_new_request_n;

  assign reqReady = (reqState == isb_pkg::ReqIdle) && ~busInit;

  // request phase: strobe then second cycle, no new request while blocked
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      reqState <= isb_pkg::ReqIdle;
      held <= '0;
    end
    else if (busInit)
      reqState <= isb_pkg::ReqIdle;
    else
    begin
      unique case (reqState)
        isb_pkg::ReqIdle:
          if (reqValid)
          begin
            held <= reqIn;
            reqState <= isb_pkg::ReqWait;
          end
        isb_pkg::ReqWait:
          if (mayIssue && busRequestIn_n == 1'b0)
            reqState <= isb_pkg::ReqFirst;
        isb_pkg::ReqFirst:
          reqState <= isb_pkg::ReqSecond;
        isb_pkg::ReqSecond:
          reqState <= isb_pkg::ReqIdle;
      endcase
    end
  end

  // lock held from the cycle after the first locked strobe until the last of the sequence ends
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      lockHeld <= 1'b0;
    else if (busInit)
      lockHeld <= 1'b0;
    else if (reqState == isb_pkg::ReqFirst && held.locked)
      lockHeld <= 1'b1;
    else if (reqState == isb_pkg::ReqSecond && held.lastOfLock)
      lockHeld <= 1'b0;
  end

  // request pin drive; wire low means asserted
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      requestStrobeOut_n <= 1'b1;
      requestStrobeOe <= 1'b0;
      requestOut_n <= '1;
      requestParityOut_n <= 1'b1;
      addressOut_n <= '1;
      addressParityOut_n <= 2'h3;
    end
    else if (reqState == isb_pkg::ReqWait && mayIssue && busRequestIn_n == 1'b0 && !busInit)
    begin
      requestStrobeOut_n <= 1'b0;
      requestStrobeOe <= 1'b1;
      requestOut_n <= ~held.typeCode;
      requestParityOut_n <= wireParity({59'h0, 1'b0, ~held.typeCode[3:0]}, 64'h1f);
      addressOut_n <= ~held.addr;
      addressParityOut_n[1] <= wireParity({31'h0, ~held.addr}, laneMask(isb_pkg::ParSplit
        - isb_pkg::AddrLo, isb_pkg::AddrHi - isb_pkg::AddrLo));
      addressParityOut_n[0] <= wireParity({31'h0, ~held.addr}, laneMask(0, isb_pkg::ParSplit
        - isb_pkg::AddrLo - 1));
    end
    else if (reqState == isb_pkg::ReqFirst && !busInit)
    begin
      requestStrobeOut_n <= 1'b1;
      requestOut_n <= ~held.sizeCode;
      requestParityOut_n <= wireParity({59'h0, 1'b1, ~held.sizeCode[3:0]}, 64'h1f);
    end
    else
    begin
      requestStrobeOut_n <= 1'b1;
      requestStrobeOe <= 1'b0;
      requestOut_n <= '1;
      requestParityOut_n <= 1'b1;
      addressOut_n <= '1;
      addressParityOut_n <= 2'h3;
    end
  end

  // requesting ownership and relaying block and lock
  assign busRequestOut_n = ~(reqState == isb_pkg::ReqWait);
  assign blockNewRequestOut_n = ~userBlock;
  assign lockOut_n = ~lockHeld;
  assign lockOe = lockHeld;

  // parity check of observed requests; strobe cycle checks type and address
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      addressErrorOut_n <= 1'b1;
      sawStrobe <= 1'b0;
      firstReq <= '0;
      firstStrobe <= 1'b0;
      seenAddr <= '0;
      seenType <= '0;
      seen <= '0;
    end
    else if (busInit)
    begin
      addressErrorOut_n <= 1'b1;
      sawStrobe <= 1'b0;
      seen <= '0;
    end
    else
    begin
      sawStrobe <= ~request_strobe_n;
      firstReq <= requestIn_n;
      firstStrobe <= request_strobe_n;
      seen.valid <= 1'b0;
      addressErrorOut_n <= 1'b1;
      if (!request_strobe_n)
      begin
        seenAddr <= ~addressIn_n;
        seenType <= ~requestIn_n;
        if (address_parity_n[1] != wireParity({31'h0, addressIn_n}, laneMask(isb_pkg::ParSplit
          - isb_pkg::AddrLo, isb_pkg::AddrHi - isb_pkg::AddrLo))
          || address_parity_n[0] != wireParity({31'h0, addressIn_n}, laneMask(0,
          isb_pkg::ParSplit - isb_pkg::AddrLo - 1))
          || request_parity_n != wireParity({59'h0, request_strobe_n, requestIn_n[3:0]},
          64'h1f))
          addressErrorOut_n <= 1'b0;
      end
      if (sawStrobe)
      begin
        seen.valid <= 1'b1;
        seen.typeCode <= seenType;
        seen.sizeCode <= ~requestIn_n;
        seen.addr <= seenAddr;
        if (request_parity_n != wireParity({59'h0, request_strobe_n, requestIn_n[3:0]}, 64'h1f))
          addressErrorOut_n <= 1'b0;
      end
    end
  end

  // snoop, defer and response drive; target ready qualifies each data beat
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      snoopCleanOut_n <= 1'b1;
      snoopDirtyOut_n <= 1'b1;
      completionDeferredOut_n <= 1'b1;
      responseCodeOut_n <= '1;
      responseParityOut_n <= 1'b1;
      targetReadyOut_n <= 1'b1;
      dataOut_n <= '1;
      dataOe <= 1'b0;
      dataByteParityOut_n <= '1;
      dataBusyOut_n <= 1'b1;
      beatsLeft <= '0;
    end
    else if (busInit)
    begin
      snoopCleanOut_n <= 1'b1;
      snoopDirtyOut_n <= 1'b1;
      completionDeferredOut_n <= 1'b1;
      responseCodeOut_n <= '1;
      responseParityOut_n <= 1'b1;
      targetReadyOut_n <= 1'b1;
      dataOe <= 1'b0;
      dataBusyOut_n <= 1'b1;
      beatsLeft <= '0;
    end
    else
    begin
      // extension drives both snoop lines together
      snoopCleanOut_n <= ~(answerValid && (answerIn.hit || answerIn.extend));
      snoopDirtyOut_n <= ~(answerValid && (answerIn.dirty || answerIn.extend));
      completionDeferredOut_n <= ~(answerValid && answerIn.defer);
      responseCodeOut_n <= answerValid ? ~answerIn.code : '1;
      responseParityOut_n <= answerValid ? wireParity({61'h0, ~answerIn.code}, 64'h7)
        : 1'b1;
      if (answerValid && answerIn.beats != 4'h0 && beatsLeft == 4'h0)
      begin
        beatsLeft <= answerIn.beats - 4'h1;
        targetReadyOut_n <= 1'b0;
        dataOe <= 1'b1;
        dataBusyOut_n <= (answerIn.beats == 4'h1);
      end
      else if (beatsLeft != 4'h0)
      begin
        beatsLeft <= beatsLeft - 4'h1;
        dataBusyOut_n <= (beatsLeft == 4'h1);
      end
      else
      begin
        targetReadyOut_n <= 1'b1;
        dataOe <= 1'b0;
        dataBusyOut_n <= 1'b1;
      end
      dataOut_n <= ~answerData;
      for (int b = 0; b < isb_pkg::Lanes; b++)
        dataByteParityOut_n[b] <= ~(^(~answerData[b*isb_pkg::LaneW +: isb_pkg::LaneW]));
    end
  end

  // incoming data and errors
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      readData <= '0;
      readValid <= 1'b0;
      busErrorOut_n <= 1'b1;
      seenBusError <= 1'b0;
      seenInit <= 1'b0;
    end
    else
    begin
      readValid <= ~target_ready_n && dataOe == 1'b0;
      if (!target_ready_n)
        readData <= ~dataIn_n;
      busErrorOut_n <= ~dataUncorrectable;
      seenBusError <= ~bus_error_n;
      seenInit <= busInit;
    end
  end

  wire unusedIn = ^{lockIn_n, snoopCleanIn_n, snoop_dirty_n, completion_deferred_n,
    response_code_n, response_parity_n, data_byte_parity_n, data_busy_n, address_error_n,
    firstReq, firstStrobe};
endmodule

//--- include/isb_pkg.sv
// package for the split-transaction i/o bus agent
// assumes all bus wires are active low open-drain, resolved by the bench
package isb_pkg;
  localparam int AddrHi = 35;
  localparam int AddrLo = 3;
  localparam int ParSplit = 24;
  localparam int ReqW = 5;
  localparam int RespW = 3;
  localparam int DataW = 64;
  localparam int LaneW = 8;
  localparam int Lanes = 8;
  localparam int Agents = 4;
  localparam logic [2:0] RespIdle = 3'h0;
  localparam logic [2:0] RespNormal = 3'h7;
  localparam logic [2:0] RespDefer = 3'h4;
  localparam logic [2:0] RespHard = 3'h2;

  typedef struct packed {
    logic [ReqW-1:0] typeCode;
    logic [ReqW-1:0] sizeCode;
    logic [AddrHi:AddrLo] addr;
    logic locked;
    logic lastOfLock;
  } isb_request_type;

  typedef struct packed {
    logic valid;
    logic [ReqW-1:0] typeCode;
    logic [ReqW-1:0] sizeCode;
    logic [AddrHi:AddrLo] addr;
  } isb_seen_type;

  typedef struct packed {
    logic [RespW-1:0] code;
    logic [3:0] beats;
    logic hit;
    logic dirty;
    logic extend;
    logic defer;
  } isb_answer_type;

  typedef enum logic [3:0] {
    ReqIdle = 4'h1,
    ReqWait = 4'h2,
    ReqFirst = 4'h4,
    ReqSecond = 4'h8
  } isb_req_state_type;
endpackage

//--- testbench/isb_agent_monitor.sv
// pin checker for the split-transaction bus agent
// assumes one clock domain; bound to every isb_agent by port name
`timescale 1ns/1ps
module isb_agent_monitor
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic reqReady,
  input wire logic busRequestIn_n,
  input wire logic priority_agent_request_n,
  input wire logic block_new_request_n,
  input wire logic requestStrobeOut_n,
  input wire logic [4:0] requestOut_n,
  input wire logic requestParityOut_n,
  input wire logic [35:3] addressOut_n,
  input wire logic [1:0] addressParityOut_n,
  input wire logic addressErrorOut_n,
  input wire logic [2:0] responseCodeOut_n,
  input wire logic responseParityOut_n,
  input wire logic targetReadyOut_n,
  input wire logic dataOe,
  input wire logic [63:0] dataOut_n,
  input wire logic [7:0] dataByteParityOut_n,
  input wire logic dataBusyOut_n,
  input wire logic bus_initialise_n,
  input wire logic dataUncorrectable,
  input wire logic busErrorOut_n
);
  // wire parity goes low when an odd number of covered wires are low
  function automatic logic par(input logic [63:0] w, input int n);
    logic p;
    p = 1'b1;
    for (int i = 0; i < n; i++) if (!w[i]) p = ~p;
    return p;
  endfunction
  function automatic logic [7:0] lanes(input logic [63:0] d);
    for (int i = 0; i < 8; i++) lanes[i] = par(64'(d[8*i+:8]), 8);
  endfunction
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  sequence s_issue;
    $fell(requestStrobeOut_n);
  endsequence
  sequence s_owner;
    !busRequestIn_n && priority_agent_request_n && block_new_request_n;
  endsequence
  property p_strobe;
    s_issue |=> requestStrobeOut_n [*2];
  endproperty
  a_strobe: assert property (p_strobe) else $error("strobe longer than one cycle");
  property p_arb;
    s_issue |-> $past(!busRequestIn_n && priority_agent_request_n && block_new_request_n);
  endproperty
  a_arb: assert property (p_arb) else $error("request issued while not owner");
  property p_qpar;
    !requestStrobeOut_n |-> requestParityOut_n == par({59'h0, 1'b0, requestOut_n[3:0]}, 5);
  endproperty
  a_qpar: assert property (p_qpar) else $error("request parity wrong");
  property p_apar;
    !requestStrobeOut_n |-> addressParityOut_n ==
      {par(64'(addressOut_n[35:24]), 12), par(64'(addressOut_n[23:3]), 21)};
  endproperty
  a_apar: assert property (p_apar) else $error("address parity wrong");
  property p_aerr;
    $fell(addressErrorOut_n) |=> addressErrorOut_n;
  endproperty
  a_aerr: assert property (p_aerr) else $error("address error not a pulse");
  property p_rpar;
    responseParityOut_n == par(64'(responseCodeOut_n), 3);
  endproperty
  a_rpar: assert property (p_rpar) else $error("response parity wrong");
  property p_trdy;
    !targetReadyOut_n |-> dataOe;
  endproperty
  a_trdy: assert property (p_trdy) else $error("ready without data");
  property p_dpar;
    dataOe |-> dataByteParityOut_n == lanes(dataOut_n);
  endproperty
  a_dpar: assert property (p_dpar) else $error("data lane parity wrong");
  property p_busy;
    !dataBusyOut_n |-> !targetReadyOut_n ##1 !targetReadyOut_n;
  endproperty
  a_busy: assert property (p_busy) else $error("busy on last beat");
  property p_berr;
    $past(rst_b) |-> busErrorOut_n == !$past(dataUncorrectable);
  endproperty
  a_berr: assert property (p_berr) else $error("bus error not reported");
  sequence s_init;
    !bus_initialise_n;
  endsequence
  property p_init;
    s_init |-> !reqReady ##1 requestStrobeOut_n;
  endproperty
  a_init: assert property (p_init) else $error("init did not idle requests");
endmodule
bind isb_agent isb_agent_monitor mon (.*);

//--- testbench/isb_bridge_model.sv
// far-side bridge agent: grants ownership and issues requests of its own
// assumes outputs are wired-and with the agent's pins; terminated lines idle high
`timescale 1ns/1ps
module isb_bridge_model
(
  input wire logic ref_clk,
  input wire logic busRequestOut_n,
  input wire logic slowGrant,
  output logic grant_n,
  output logic pS_n,
  output logic [4:0] pQ_n,
  output logic pReqPar_n,
  output logic [35:3] pA_n,
  output logic [1:0] pAddrPar_n
);
  int waitCnt = 0;
  function automatic logic par(input logic [63:0] w, input int n);
    logic p;
    p = 1'b1;
    for (int i = 0; i < n; i++) if (!w[i]) p = ~p;
    return p;
  endfunction
  initial
  begin
    {grant_n, pS_n, pQ_n, pReqPar_n, pA_n, pAddrPar_n} = '1;
  end
  // slow grants give the agent a long wait for ownership
  always @(negedge ref_clk)
  begin
    waitCnt = busRequestOut_n ? 0 : waitCnt + 1;
    grant_n <= !(waitCnt > (slowGrant ? 3 : 0));
  end
  // a second agent on the shared bus; bad flips request parity on purpose
  task automatic send(input logic [4:0] t, input logic [4:0] s, input logic [35:3] a,
    input logic bad);
    @(negedge ref_clk);
    pS_n = 1'b0;
    pQ_n = ~t;
    pA_n = ~a;
    pReqPar_n = par({59'h0, 1'b0, ~t[3:0]}, 5) ^ bad;
    pAddrPar_n = {par(64'(~a[35:24]), 12), par(64'(~a[23:3]), 21)};
    @(negedge ref_clk);
    pS_n = 1'b1;
    pQ_n = ~s;
    pReqPar_n = par({59'h0, 1'b1, ~s[3:0]}, 5);
    @(negedge ref_clk);
    {pQ_n, pReqPar_n, pA_n, pAddrPar_n} = '1;
  endtask
endmodule

//--- testbench/io_split_bus_agent_test.sv
// self-checking bench: one agent, one far-side bridge model, wired-and pins
// assumes inputs change at the falling edge and outputs settle by then
`timescale 1ns/1ps
module io_split_bus_agent_test;
  logic ref_clk = 0;
  logic rst_b = 0;
  logic reqValid = 0;
  isb_pkg::isb_request_type reqIn = '0;
  logic priority_agent_request_n = 1;
  logic blk_n = 1;
  logic bus_initialise_n = 1;
  logic answerValid = 0;
  isb_pkg::isb_answer_type answerIn = '0;
  logic [63:0] answerData = '0;
  logic dataUncorrectable = 0, userBlock = 0, slowGrant = 0;
  logic reqReady, busRequestOut_n, blockNewRequestOut_n, lockOut_n, lockOe;
  logic requestStrobeOut_n, requestStrobeOe, requestParityOut_n, addressErrorOut_n;
  logic [4:0] requestOut_n, pQ_n;
  logic [35:3] addressOut_n, pA_n;
  logic [1:0] addressParityOut_n, pAddrPar_n;
  logic snoopCleanOut_n, snoopDirtyOut_n, completionDeferredOut_n, responseParityOut_n;
  logic [2:0] responseCodeOut_n;
  logic targetReadyOut_n, dataOe, dataBusyOut_n, busErrorOut_n, readValid;
  logic [63:0] dataOut_n, readData;
  logic [7:0] dataByteParityOut_n;
  logic seenBusError, seenInit, grant_n, pS_n, pReqPar_n;
  logic lk = 0;
  isb_pkg::isb_seen_type seen;
  logic [31:0] rnd = 32'ha0bc;
  int n_fail = 0;
  int total_checks = 0;
  always #2 ref_clk = ~ref_clk;
  isb_agent dut
  (
    .*,
    .busRequestIn_n(grant_n),
    .block_new_request_n(blockNewRequestOut_n & blk_n),
    .lockIn_n(!lockOe | lockOut_n),
    .request_strobe_n((!requestStrobeOe | requestStrobeOut_n) & pS_n),
    .requestIn_n(requestOut_n & pQ_n),
    .request_parity_n(requestParityOut_n & pReqPar_n),
    .addressIn_n(addressOut_n & pA_n),
    .address_parity_n(addressParityOut_n & pAddrPar_n),
    .address_error_n(addressErrorOut_n),
    .snoopCleanIn_n(snoopCleanOut_n),
    .snoop_dirty_n(snoopDirtyOut_n),
    .completion_deferred_n(completionDeferredOut_n),
    .response_code_n(responseCodeOut_n),
    .response_parity_n(responseParityOut_n),
    .target_ready_n(targetReadyOut_n),
    .dataIn_n(dataOe ? dataOut_n : '1),
    .data_byte_parity_n(dataOe ? dataByteParityOut_n : '1),
    .data_busy_n(dataBusyOut_n),
    .bus_error_n(busErrorOut_n)
  );
  isb_bridge_model far (.*);
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  function automatic logic par(input logic [63:0] w, input int n);
    logic p;
    p = 1'b1;
    for (int i = 0; i < n; i++) if (!w[i]) p = ~p;
    return p;
  endfunction
  task automatic tick(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // who picks the stall: 0 priority agent, 1 far block, 2 own block, 3 none
  task automatic issue(input int hold, input int who);
    int w;
    rnd = lfsr(rnd);
    reqIn = '0;
    reqIn.typeCode = rnd[4:0];
    reqIn.sizeCode = rnd[9:5];
    reqIn.locked = rnd[10];
    reqIn.lastOfLock = rnd[11];
    rnd = lfsr(rnd);
    reqIn.addr = {rnd, rnd[7]};
    priority_agent_request_n = who != 0;
    blk_n = who != 1;
    userBlock = who == 2;
    reqValid = 1;
    tick(1);
    reqValid = 0;
    w = 0;
    while (requestStrobeOut_n === 1'b1 && w < 40)
    begin
      w++;
      if (w == hold) {priority_agent_request_n, blk_n, userBlock} = 3'b110;
      tick(1);
    end
    // no issue before both the stall and the far side's grant (1 or 4 cycles) are gone
    chk(w, (hold > (slowGrant ? 4 : 1)) ? hold : (slowGrant ? 4 : 1));
    chk(requestOut_n, {~reqIn.typeCode});
    chk(addressOut_n, {~reqIn.addr});
    chk(requestParityOut_n, par({59'h0, 1'b0, ~reqIn.typeCode[3:0]}, 5));
    chk(addressParityOut_n, {par(64'({~reqIn.addr[35:24]}), 12),
      par(64'({~reqIn.addr[23:3]}), 21)});
    chk(lockOut_n, !lk);
    tick(1);
    chk(requestStrobeOut_n, 1);
    chk(requestOut_n, {~reqIn.sizeCode});
    chk(lockOut_n, !(lk | reqIn.locked));
    lk = (lk | reqIn.locked) & !reqIn.lastOfLock;
  endtask
  task automatic answer(input int n);
    int w;
    int b;
    rnd = lfsr(rnd);
    answerIn = '0;
    answerIn.code = rnd[2:0];
    answerIn.beats = 4'(n);
    answerIn.hit = rnd[6];
    answerIn.dirty = rnd[7];
    answerIn.extend = rnd[8];
    answerIn.defer = rnd[9];
    answerData = {rnd, ~rnd};
    dataUncorrectable = rnd[5];
    answerValid = 1;
    tick(1);
    chk(busErrorOut_n, {~dataUncorrectable});
    chk(snoopCleanOut_n, !(answerIn.hit | answerIn.extend));
    chk(snoopDirtyOut_n, !(answerIn.dirty | answerIn.extend));
    chk(completionDeferredOut_n, !answerIn.defer);
    chk(responseCodeOut_n, {~answerIn.code});
    answerValid = 0;
    dataUncorrectable = 0;
    w = 0;
    while (targetReadyOut_n !== 1'b0 && w < 20)
    begin
      w++;
      tick(1);
    end
    w = 0;
    b = 0;
    while (targetReadyOut_n === 1'b0 && w < 20)
    begin
      if (w == 1) chk(seenBusError, rnd[5]);
      chk(dataOut_n, ~answerData);
      if (dataBusyOut_n === 1'b0) b++;
      w++;
      tick(1);
    end
    chk(w, n);
    chk(b, n - 1);
    chk(readData, answerData);
    chk(readValid, 0);
  endtask
  initial
  begin
    #20000;
    n_fail++;
    complete_run();
  end
  initial
  begin
    logic e;
    logic v;
    tick(2);
    rst_b = 1;
    tick(1);
    for (int i = 0; i < 8; i++)
    begin
      rnd = lfsr(rnd);
      slowGrant = rnd[0];
      issue(i % 4 == 3 ? 0 : 1 + rnd[3:1], i % 4);
      tick(3);
    end
    answer(1);
    answer(2);
    answer(4);
    answer(15);
    for (int b = 0; b < 2; b++)
    begin
      {e, v} = 2'b00;
      rnd = lfsr(rnd);
      fork
        far.send(rnd[4:0], rnd[9:5], {rnd, rnd[3]}, b[0]);
        repeat (8)
        begin
          tick(1);
          if (addressErrorOut_n === 1'b0) e = 1;
          if (seen.valid === 1'b1) v = 1;
        end
      join
      chk(e, b);
      chk(v, 1);
      chk(seen.typeCode, rnd[4:0]);
      chk(seen.sizeCode, rnd[9:5]);
      chk(seen.addr, {rnd, rnd[3]});
    end
    priority_agent_request_n = 0;
    reqValid = 1;
    tick(1);
    reqValid = 0;
    bus_initialise_n = 0;
    tick(1);
    chk(reqReady, 0);
    chk(seenInit, 1);
    bus_initialise_n = 1;
    priority_agent_request_n = 1;
    e = 0;
    repeat (10)
    begin
      tick(1);
      if (requestStrobeOut_n !== 1'b1) e = 1;
    end
    chk(e, 0);
    chk(reqReady, 1);
    complete_run();
  end
endmodule
